// ===== pkg/lce_consts.svh
// Offsets, field positions, reset values and timing counts of the loop channel
`ifndef LCE_CONSTS_SVH
`define LCE_CONSTS_SVH
`define LCE_CLK_HZ      10000000
`define LCE_SEC_CYC     (`LCE_CLK_HZ)
`define LCE_REARM_S     16'h0004
`define LCE_RETRY_S     16'h003C
`define LCE_CORR_MAX    5'h14
`define LCE_CORR_T0     5'h08
`define LCE_CORR_T1     5'h0A
`define LCE_CORR_T2     5'h0C
`define LCE_CORR_T3     5'h0E
`define LCE_OFF_CTRL    6'h00
`define LCE_OFF_CORR    6'h04
`define LCE_OFF_HOLD    6'h08
`define LCE_OFF_AMAX    6'h0C
`define LCE_OFF_NOISE   6'h10
`define LCE_OFF_ADDR    6'h14
`define LCE_OFF_STAT    6'h18
`define LCE_OFF_DIAG    6'h1C
`define LCE_OFF_LEN     6'h20
`define LCE_B_DIR_EN    0
`define LCE_B_NORM      1
`define LCE_B_NC        2
`define LCE_B_ERR_FREE  3
`define LCE_B_AUTO      4
`define LCE_B_ALIGN     5
`define LCE_CTRL_RST    6'h00
`define LCE_HOLD_RST    16'h0000
`define LCE_AMAX_RST    16'h0000
`define LCE_NOISE_RST   16'h0010
`define LCE_ADDR_RST    8'h01
`endif

// ===== pkg/lce_pkg.sv
// Types of the loop channel evaluation block
package lce_pkg;
  typedef enum logic [2:0] {
    LCE_FREE  = 3'b000,
    LCE_OCC   = 3'b001,
    LCE_IGN   = 3'b010,
    LCE_ALIGN = 3'b011,
    LCE_FAULT = 3'b100
  } lce_state_type;
  typedef struct packed {
    logic [7:0] len;
    logic       dir;
  } lce_veh_in_type;
  typedef struct packed {
    logic [7:0] len;
    logic       ww;
    logic       tag_ww;
    logic       tag_sfx;
  } lce_veh_out_type;
endpackage

// ===== logic/lce_top.sv
// Loop channel evaluation with classic Wishbone register slave
`timescale 1ns/100ps
`include "lce_consts.svh"
// Function
// - Length is attenuation minus correction, correction 0..20
// - Default correction preloaded from loop type
// - Wrong-way flag set against normal direction
// - Flag zero when off, else opposite direction
// - Readout tag normal or wrong-way, suffix direction
// - Direction evaluation off suppresses wrong-way everywhere
// - Bus address from parameter or wired inputs
// - Sensitivity not user adjustable
// - Hold expiry resets channel, ignores present vehicle
// - Full sensitivity 4 s after vehicle leaves
// - Count hold-expiry alignments as diagnostic
// - Polarity sets unoccupied output levels
// - Detection inverts outputs from unoccupied state
// - Error drives output per configuration bit
// - Alignment over maximum aborts, zero disables
// - Auto realign retries faulted channel every minute
// - Noise threshold clamped around switch-on threshold
// - Noise threshold suppresses small disturbances
// - Occupied above turn-on threshold, free below
module lce_top import lce_pkg::*; #(
  parameter int SEC_CYC = `LCE_SEC_CYC
) (
  input  wire logic            mclk_i,
  input  wire logic            nrst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [5:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic                 wb_ack_o,
  output logic      [31:0]     wb_dat_o,
  input  wire logic [15:0]     amp_i,
  input  wire logic [15:0]     thr_on_i,
  input  wire logic [1:0]      loop_type_i,
  input  wire logic            veh_vld_i,
  input  wire lce_veh_in_type  veh_i,
  input  wire logic            align_done_i,
  input  wire logic            align_err_i,
  input  wire logic [7:0]      hw_addr_i,
  input  wire logic            hw_addr_en_i,
  output logic                 veh_vld_o,
  output lce_veh_out_type      veh_o,
  output logic                 align_req_o,
  output logic                 occupied_o,
  output logic                 fault_o,
  output logic                 relay_o,
  output logic                 oc_o,
  output logic      [7:0]      bus_addr_o,
  output logic      [15:0]     noise_thr_o
);
  // ----------------------------------------------------------------
  // Address pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pin_s1_reg;
  logic [8:0] pin_s2_reg;
  logic [8:0] pin_s3_reg;
  logic [8:0] pin_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_pin
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_reg[gi]    <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= (gi == 8) ? hw_addr_en_i : hw_addr_i[gi % 8];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers and Wishbone slave
  // ----------------------------------------------------------------
  logic [5:0]    ctrl_reg;
  logic [4:0]    corr_reg;
  logic          corr_set_reg;
  logic [15:0]   hold_reg;
  logic [15:0]   amax_reg;
  logic [15:0]   noise_reg;
  logic [7:0]    addr_reg;
  logic [15:0]   diag_reg;
  logic [7:0]    len_reg;
  logic          ack_reg;
  logic [31:0]   rd_next;
  logic          wr_fire;
  logic          rd_acc;
  logic [4:0]    corr_eff;
  logic [15:0]   noise_clamp;
  lce_state_type st_reg;
  logic          hold_exp;
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign rd_acc  = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb begin
    case (loop_type_i)
      2'h0:    corr_eff = `LCE_CORR_T0;
      2'h1:    corr_eff = `LCE_CORR_T1;
      2'h2:    corr_eff = `LCE_CORR_T2;
      default: corr_eff = `LCE_CORR_T3;
    endcase
    if (corr_set_reg) begin
      corr_eff = corr_reg;
    end
  end

  always_comb begin
    case (wb_adr_i)
      `LCE_OFF_CTRL:  rd_next = {26'h0, ctrl_reg};
      `LCE_OFF_CORR:  rd_next = {27'h0, corr_eff};
      `LCE_OFF_HOLD:  rd_next = {16'h0, hold_reg};
      `LCE_OFF_AMAX:  rd_next = {16'h0, amax_reg};
      `LCE_OFF_NOISE: rd_next = {16'h0, noise_clamp};
      `LCE_OFF_ADDR:  rd_next = {24'h0, bus_addr_o};
      `LCE_OFF_STAT:  rd_next = {26'h0, pin_reg[8], fault_o, occupied_o, st_reg};
      `LCE_OFF_DIAG:  rd_next = {16'h0, diag_reg};
      `LCE_OFF_LEN:   rd_next = {24'h0, len_reg};
      default:        rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_reg <= rd_acc;
      if (rd_acc) begin
        wb_dat_o <= rd_next;
      end
    end
  end
  assign wb_ack_o = ack_reg;

  // Configuration writes; byte lane 0, and lanes 0 and 1 for the 16-bit fields
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg     <= `LCE_CTRL_RST;
      corr_reg     <= 5'h00;
      corr_set_reg <= 1'b0;
      hold_reg     <= `LCE_HOLD_RST;
      amax_reg     <= `LCE_AMAX_RST;
      noise_reg    <= `LCE_NOISE_RST;
      addr_reg     <= `LCE_ADDR_RST;
    end else begin
      ctrl_reg[`LCE_B_ALIGN] <= 1'b0;
      if (wr_fire && wb_sel_i[0]) begin
        case (wb_adr_i)
          `LCE_OFF_CTRL: ctrl_reg <= wb_dat_i[5:0];
          `LCE_OFF_CORR: begin
            if (wb_dat_i[7:0] <= {3'h0, `LCE_CORR_MAX}) begin
              corr_reg     <= wb_dat_i[4:0];
              corr_set_reg <= 1'b1;
            end
          end
          `LCE_OFF_ADDR: addr_reg <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      if (wr_fire && wb_sel_i[0] && wb_sel_i[1]) begin
        case (wb_adr_i)
          `LCE_OFF_HOLD:  hold_reg  <= wb_dat_i[15:0];
          `LCE_OFF_AMAX:  amax_reg  <= wb_dat_i[15:0];
          `LCE_OFF_NOISE: noise_reg <= wb_dat_i[15:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Seconds tick and noise limit
  // ----------------------------------------------------------------
  logic [31:0] div_reg;
  logic        sec_tick;
  assign sec_tick = (div_reg == 32'(SEC_CYC - 1));
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= sec_tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  // Limits an eighth and a half of the switch-on threshold
  logic [15:0] amp_eff;
  always_comb begin
    noise_clamp = noise_reg;
    if (noise_reg < {3'h0, thr_on_i[15:3]}) begin
      noise_clamp = {3'h0, thr_on_i[15:3]};
    end else if (noise_reg > {1'h0, thr_on_i[15:1]}) begin
      noise_clamp = {1'h0, thr_on_i[15:1]};
    end
    amp_eff = (amp_i < noise_clamp) ? 16'h0 : amp_i;
  end

  // ----------------------------------------------------------------
  // Channel state machine
  // ----------------------------------------------------------------
  logic          raw_occ;
  logic [15:0]   tcnt_reg;
  logic          rearm_done;
  logic          align_tmo;
  logic          retry;
  logic          sw_align;
  lce_state_type st_next;
  assign raw_occ    = amp_eff > thr_on_i;
  assign hold_exp   = (st_reg == LCE_OCC) && raw_occ && (hold_reg != 16'h0)
                      && (tcnt_reg >= hold_reg);
  assign rearm_done = (st_reg == LCE_IGN) && (tcnt_reg >= `LCE_REARM_S);
  assign align_tmo  = (st_reg == LCE_ALIGN) && (amax_reg != 16'h0)
                      && (tcnt_reg >= amax_reg);
  assign retry      = (st_reg == LCE_FAULT) && ctrl_reg[`LCE_B_AUTO]
                      && (tcnt_reg >= `LCE_RETRY_S);
  assign sw_align   = ctrl_reg[`LCE_B_ALIGN];

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      LCE_FREE:  if (raw_occ) st_next = LCE_OCC;
      LCE_OCC: begin
        if (!raw_occ) begin
          st_next = LCE_FREE;
        end else if (hold_exp) begin
          st_next = LCE_IGN;
        end
      end
      LCE_IGN:   if (rearm_done && !raw_occ) st_next = LCE_FREE;
      LCE_ALIGN: begin
        if (align_err_i || align_tmo) begin
          st_next = LCE_FAULT;
        end else if (align_done_i) begin
          st_next = LCE_FREE;
        end
      end
      LCE_FAULT: if (retry) st_next = LCE_ALIGN;
      default:   st_next = LCE_FREE;
    endcase
    if (sw_align) begin
      st_next = LCE_ALIGN;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= LCE_FREE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Seconds in the current state; the rearm interval restarts on each vehicle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tcnt_reg <= 16'h0;
    end else if (st_next != st_reg) begin
      tcnt_reg <= 16'h0;
    end else if (st_reg == LCE_IGN && raw_occ) begin
      tcnt_reg <= 16'h0;
    end else if (sec_tick && tcnt_reg != 16'hFFFF) begin
      tcnt_reg <= tcnt_reg + 16'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      diag_reg    <= 16'h0;
      align_req_o <= 1'b0;
    end else begin
      align_req_o <= hold_exp | retry | sw_align;
      if (hold_exp) begin
        diag_reg <= diag_reg + 16'h1;
      end else if (wr_fire && wb_adr_i == `LCE_OFF_DIAG) begin
        diag_reg <= 16'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Switching outputs and address
  // ----------------------------------------------------------------
  logic occ_eff;
  assign occ_eff = (st_reg == LCE_OCC) ||
                   (st_reg == LCE_FAULT && !ctrl_reg[`LCE_B_ERR_FREE]);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      occupied_o  <= 1'b0;
      fault_o     <= 1'b0;
      relay_o     <= 1'b0;
      oc_o        <= 1'b1;
      bus_addr_o  <= `LCE_ADDR_RST;
      noise_thr_o <= `LCE_NOISE_RST;
    end else begin
      occupied_o  <= occ_eff;
      fault_o     <= st_reg == LCE_FAULT;
      relay_o     <= occ_eff ^ ctrl_reg[`LCE_B_NC];
      oc_o        <= ~(occ_eff ^ ctrl_reg[`LCE_B_NC]);
      bus_addr_o  <= pin_reg[8] ? pin_reg[7:0] : addr_reg;
      noise_thr_o <= noise_clamp;
    end
  end

  // ----------------------------------------------------------------
  // Vehicle evaluation
  // ----------------------------------------------------------------
  logic [7:0] len_next;
  logic       ww_next;
  assign len_next = (veh_i.len >= {3'h0, corr_eff}) ?
                    veh_i.len - {3'h0, corr_eff} : 8'h00;
  assign ww_next  = ctrl_reg[`LCE_B_DIR_EN] &&
                    (veh_i.dir != ctrl_reg[`LCE_B_NORM]);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      veh_vld_o <= 1'b0;
      veh_o     <= '0;
      len_reg   <= 8'h00;
    end else begin
      veh_vld_o <= veh_vld_i && st_reg != LCE_IGN;
      if (veh_vld_i && st_reg != LCE_IGN) begin
        veh_o.len     <= len_next;
        veh_o.ww      <= ww_next;
        veh_o.tag_ww  <= ww_next;
        veh_o.tag_sfx <= veh_i.dir;
        len_reg       <= len_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_len;
    veh_vld_i && st_reg != LCE_IGN |=> veh_vld_o && veh_o.len == $past(len_next);
  endproperty
  a_len: assert property (p_len) else $error("length wrong");
  property p_sat;
    veh_vld_i && st_reg != LCE_IGN && veh_i.len < {3'h0, corr_eff} |=> veh_o.len == 8'h00;
  endproperty
  a_sat: assert property (p_sat) else $error("length not saturated");
  property p_off;
    veh_vld_i && st_reg != LCE_IGN && !ctrl_reg[`LCE_B_DIR_EN]
      |=> !veh_o.ww && !veh_o.tag_ww;
  endproperty
  a_off: assert property (p_off) else $error("wrong-way while off");
  property p_ww;
    veh_vld_i && st_reg != LCE_IGN && ctrl_reg[`LCE_B_DIR_EN]
      |=> veh_o.tag_sfx == $past(veh_i.dir)
          && veh_o.ww == ($past(veh_i.dir) != $past(ctrl_reg[`LCE_B_NORM]));
  endproperty
  a_ww: assert property (p_ww) else $error("wrong-way flag wrong");
  property p_pol;
    ##1 relay_o == ~oc_o && relay_o == (occupied_o ^ $past(ctrl_reg[`LCE_B_NC]));
  endproperty
  a_pol: assert property (p_pol) else $error("switching output wrong");
  property p_hold;
    hold_exp && !sw_align
      |=> st_reg == LCE_IGN && diag_reg == $past(diag_reg) + 16'h1 && align_req_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold expiry not handled");
  property p_ign;
    st_reg == LCE_IGN && raw_occ && !sw_align |=> st_reg == LCE_IGN && tcnt_reg == 16'h0;
  endproperty
  a_ign: assert property (p_ign) else $error("rearm not restarted");
  property p_tmo;
    align_tmo && !sw_align |=> st_reg == LCE_FAULT ##1 fault_o;
  endproperty
  a_tmo: assert property (p_tmo) else $error("alignment not aborted");
  property p_noise;
    ##1 noise_thr_o <= {1'h0, $past(thr_on_i[15:1])}
        && noise_thr_o >= {3'h0, $past(thr_on_i[15:3])};
  endproperty
  a_noise: assert property (p_noise) else $error("noise outside limits");
  property p_addr;
    pin_reg[8] |=> bus_addr_o == $past(pin_reg[7:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address source wrong");

  c_hold:  cover property (hold_exp);
  c_ww:    cover property (veh_vld_o && veh_o.ww);
  c_tmo:   cover property (align_tmo);
  c_rearm: cover property (rearm_done);
endmodule

// ===== tb/lce_front_model.sv
// Loop measurement front end answering alignment requests of the channel
`timescale 1ns/100ps
module lce_front_model (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       align_req_i,
  input  wire logic [1:0] mode_i,
  output logic            align_done_o,
  output logic            align_err_o
);
  int cnt;
  // Mode 0 ok after 3 cycles, 1 ok after 30, 2 failure after 3, 3 never answers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt          <= 0;
      align_done_o <= 1'b0;
      align_err_o  <= 1'b0;
    end else begin
      align_done_o <= 1'b0;
      align_err_o  <= 1'b0;
      if (align_req_i) begin
        cnt <= (mode_i == 2'h1) ? 30 : 3;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1 && mode_i != 2'h3) begin
          align_done_o <= (mode_i != 2'h2);
          align_err_o  <= (mode_i == 2'h2);
        end
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench of the loop channel evaluation block
`timescale 1ns/100ps
`include "lce_consts.svh"
module tb import lce_pkg::*; ;
  localparam int SC = 10;
  logic            mclk_i = 1'b0, nrst_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic            wb_we_i = 1'b0, veh_vld_i = 1'b0, hw_addr_en_i = 1'b0;
  logic [5:0]      wb_adr_i = 6'h00;
  logic [3:0]      wb_sel_i = 4'hF, sel = 4'hF;
  logic [31:0]     wb_dat_i = 32'h0, q, rs = 32'hC083;
  logic [15:0]     amp_i = 16'h0000, thr_on_i = 16'h0040;
  logic [1:0]      loop_type_i = 2'h0, mode = 2'h0;
  logic [7:0]      hw_addr_i = 8'h00;
  lce_veh_in_type  veh_i = '0;
  logic [5:0]      ctrl = 6'h00;
  logic            wb_ack_o, veh_vld_o, align_req_o, occupied_o, fault_o, relay_o, oc_o;
  logic            align_done_i, align_err_i;
  logic [31:0]     wb_dat_o;
  lce_veh_out_type veh_o;
  logic [7:0]      bus_addr_o;
  logic [15:0]     noise_thr_o;
  int              bad_count = 0, n_compared = 0, corr = 10, cyc_cnt = 0, nreq = 0;
  int              lt, w, n0;

  always #50 mclk_i = ~mclk_i;

  lce_top #(.SEC_CYC(SC)) lce_top_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .amp_i(amp_i), .thr_on_i(thr_on_i),
    .loop_type_i(loop_type_i), .veh_vld_i(veh_vld_i), .veh_i(veh_i),
    .align_done_i(align_done_i), .align_err_i(align_err_i), .hw_addr_i(hw_addr_i),
    .hw_addr_en_i(hw_addr_en_i), .veh_vld_o(veh_vld_o), .veh_o(veh_o),
    .align_req_o(align_req_o), .occupied_o(occupied_o), .fault_o(fault_o),
    .relay_o(relay_o), .oc_o(oc_o), .bus_addr_o(bus_addr_o), .noise_thr_o(noise_thr_o));

  lce_front_model lce_front_model_i (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .align_req_i(align_req_o), .mode_i(mode),
    .align_done_o(align_done_i), .align_err_o(align_err_i));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle: hold request until ack is sampled, then release for a cycle
  task automatic wb(input logic w_en, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w_en;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk_i);
    end
    if (n == 20) chk(32'h0, 32'h1, "bus ack missing");
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp, "register read");
  endtask

  // Expected record from the reference model of length and direction
  task automatic veh(input int len, input logic dir, input logic drop);
    logic [7:0] el;
    logic       ww;
    el = (len > corr) ? 8'(len - corr) : 8'h00;
    ww = ctrl[`LCE_B_DIR_EN] & (dir ^ ctrl[`LCE_B_NORM]);
    @(posedge mclk_i);
    veh_vld_i <= 1'b1;
    veh_i     <= {8'(len), dir};
    @(posedge mclk_i);
    veh_vld_i <= 1'b0;
    @(posedge mclk_i);
    chk(32'(veh_vld_o), 32'(!drop), "vehicle valid");
    if (!drop) chk(32'(veh_o), 32'({el, ww, ww, dir}), "vehicle record");
  endtask

  always @(posedge mclk_i) begin
    if (align_req_o === 1'b1) nreq++;
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      bad_count++;
      $display("Error at %0t: run timed out", $time);
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    chk(32'({relay_o, oc_o, bus_addr_o}), 32'h101, "reset outputs");
    nrst_i <= 1'b1;
    for (lt = 0; lt < 4; lt++) begin
      loop_type_i <= 2'(lt);
      rd(`LCE_OFF_CORR, 32'(8 + 2 * lt));
    end
    loop_type_i <= 2'h1;
    rd(`LCE_OFF_CTRL, 32'h0);
    rd(`LCE_OFF_NOISE, 32'h10);
    wb(1'b1, 6'h3C, 32'hFF);
    rd(6'h3C, 32'h0);
    wb(1'b1, `LCE_OFF_NOISE, 32'h1);
    rd(`LCE_OFF_NOISE, 32'h8);
    wb(1'b1, `LCE_OFF_NOISE, 32'hC8);
    rd(`LCE_OFF_NOISE, 32'h20);
    chk(32'(noise_thr_o), 32'h20, "noise output");
    wb(1'b1, `LCE_OFF_CORR, 32'h15);
    rd(`LCE_OFF_CORR, 32'hA);
    wb(1'b1, `LCE_OFF_CORR, 32'h14);
    corr = 20;
    rd(`LCE_OFF_CORR, 32'h14);
    veh(30, 1'b0, 1'b0);
    veh(20, 1'b1, 1'b0);
    veh(5, 1'b0, 1'b0);
    for (lt = 0; lt < 4; lt++) begin
      ctrl = 6'(lt);
      wb(1'b1, `LCE_OFF_CTRL, 32'(ctrl));
      veh(int'(rnd() % 256), 1'b0, 1'b0);
      veh(int'(rnd() % 256), 1'b1, 1'b0);
    end
    wb(1'b1, `LCE_OFF_ADDR, 32'h33);
    repeat (3) @(posedge mclk_i);
    chk(32'(bus_addr_o), 32'h33, "parameter address");
    hw_addr_en_i <= 1'b1;
    hw_addr_i    <= 8'h5A;
    repeat (6) @(posedge mclk_i);
    chk(32'(bus_addr_o), 32'h5A, "pin address");
    rd(`LCE_OFF_ADDR, 32'h5A);
    for (lt = 0; lt < 2; lt++) begin
      ctrl = 6'(lt << `LCE_B_NC);
      wb(1'b1, `LCE_OFF_CTRL, 32'(ctrl));
      repeat (4) @(posedge mclk_i);
      chk(32'({relay_o, oc_o}), 32'(lt ? 2 : 1), "free outputs");
      amp_i <= 16'h0041 + 16'(rnd() % 100);
      repeat (4) @(posedge mclk_i);
      chk(32'({occupied_o, relay_o, oc_o}), 32'(lt ? 5 : 6), "occupied outputs");
      amp_i <= 16'h0040;
      repeat (4) @(posedge mclk_i);
      chk(32'(occupied_o), 32'h0, "threshold equal");
    end
    ctrl = 6'h00;
    wb(1'b1, `LCE_OFF_CTRL, 32'h0);
    sel = 4'h1;
    wb(1'b1, `LCE_OFF_HOLD, 32'h1);
    sel = 4'hF;
    rd(`LCE_OFF_HOLD, 32'h0);
    wb(1'b1, `LCE_OFF_HOLD, 32'h1);
    amp_i <= 16'h0100;
    repeat (25) @(posedge mclk_i);
    chk(32'(occupied_o), 32'h0, "hold expiry");
    rd(`LCE_OFF_DIAG, 32'h1);
    veh(40, 1'b0, 1'b1);
    amp_i <= 16'h0000;
    repeat (30) @(posedge mclk_i);
    wb(1'b0, `LCE_OFF_STAT, 32'h0);
    chk(32'(q[2:0]), 32'h2, "still ignoring");
    repeat (15) @(posedge mclk_i);
    wb(1'b0, `LCE_OFF_STAT, 32'h0);
    chk(32'(q[2:0]), 32'h0, "rearmed");
    wb(1'b1, `LCE_OFF_HOLD, 32'h0);
    wb(1'b1, `LCE_OFF_DIAG, 32'h0);
    rd(`LCE_OFF_DIAG, 32'h0);
    mode = 2'h3;
    wb(1'b1, `LCE_OFF_AMAX, 32'h1);
    wb(1'b1, `LCE_OFF_CTRL, 32'h20);
    repeat (20) @(posedge mclk_i);
    chk(32'({fault_o, relay_o}), 32'h3, "fault shows occupied");
    wb(1'b1, `LCE_OFF_CTRL, 32'h08);
    repeat (3) @(posedge mclk_i);
    chk(32'({fault_o, relay_o}), 32'h2, "fault shows free");
    mode = 2'h0;
    wb(1'b1, `LCE_OFF_CTRL, 32'h18);
    n0 = nreq;
    w = 0;
    while (nreq == n0 && w < 700) begin
      @(posedge mclk_i);
      w++;
    end
    chk(32'(w > 500 && w < 620), 32'h1, "retry period");
    repeat (10) @(posedge mclk_i);
    chk(32'(fault_o), 32'h0, "retry recovers");
    wb(1'b1, `LCE_OFF_AMAX, 32'h0);
    mode <= 2'h2;
    wb(1'b1, `LCE_OFF_CTRL, 32'h20);
    repeat (10) @(posedge mclk_i);
    chk(32'({fault_o, relay_o}), 32'h3, "alignment error");
    mode <= 2'h1;
    wb(1'b1, `LCE_OFF_CTRL, 32'h20);
    repeat (40) @(posedge mclk_i);
    chk(32'({fault_o, occupied_o}), 32'h0, "no alignment limit");
    report_and_stop();
  end
endmodule
